// *** hdl/e1pm_pkg.sv ***
package e1pm_pkg;
  // register indices (printed offsets are not all multiples of four)
  localparam logic [11:0] FAS_HI_IDX = 12'h902;
  localparam logic [11:0] FAS_LO_IDX = 12'h903;
  localparam logic [11:0] SEF_IDX = 12'h904;
  localparam logic [11:0] CRC_HI_IDX = 12'h905;
  localparam logic [11:0] CRC_LO_IDX = 12'h906;
  localparam logic [11:0] IRQ_STAT_IDX = 12'h910;
  localparam logic [11:0] IRQ_MASK_IDX = 12'h911;
  localparam logic [11:0] EVT_STAT_IDX = 12'h912;
  localparam int ADDR_W = 14;
  // interrupt status bit positions
  localparam int IRQ_FAS = 0;
  localparam int IRQ_SEF = 1;
  localparam int IRQ_CRC = 2;
  localparam int IRQ_SAT = 3;
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic [15:0] CNT16_RST = 16'h0000;
  localparam logic [7:0] CNT8_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/e1pm_cnt16.sv ***
`timescale 1ns/1ps
module e1pm_cnt16
  import e1pm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // event and clearing reads
  input wire logic event_pulse,
  input wire logic rd_hi,
  input wire logic rd_lo,
  // value
  output logic [7:0] hi_byte,
  output logic [7:0] lo_byte,
  output logic saturated
);
  logic [15:0] count;
  logic [7:0] lo_snap;
  logic hi_done;
  logic [15:0] base;

  // an upper-byte read freezes the lower byte and restarts the count
  assign base = rd_hi ? CNT16_RST : count;
  assign saturated = event_pulse && (count == 16'hFFFF) && !rd_hi;
  assign hi_byte = count[15:8];
  assign lo_byte = hi_done ? lo_snap : count[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= CNT16_RST;
    end else if (event_pulse && base != 16'hFFFF) begin
      count <= base + 16'h0001;
    end else begin
      count <= base;
    end
  end

  // clear completes on the lower-byte read that follows the upper-byte read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_done <= 1'b0;
      lo_snap <= CNT8_RST;
    end else if (rd_hi) begin
      hi_done <= 1'b1;
      lo_snap <= count[7:0];
    end else if (rd_lo) begin
      hi_done <= 1'b0;
    end
  end
endmodule

// *** hdl/e1pm_sef.sv ***
`timescale 1ns/1ps
module e1pm_sef
  import e1pm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // framer strobes and clearing read
  input wire logic fas_word_valid,
  input wire logic fas_word_err,
  input wire logic loss_of_frame,
  input wire logic rd_clear,
  // value
  output logic [7:0] count,
  output logic sef_pulse,
  output logic saturated
);
  logic prev_err;
  logic [7:0] base;

  // two consecutive bad alignment words while in frame
  assign sef_pulse = fas_word_valid && fas_word_err && prev_err && !loss_of_frame;
  assign base = rd_clear ? CNT8_RST : count;
  assign saturated = sef_pulse && (count == 8'hFF) && !rd_clear;

  always_ff @(posedge aclk) begin
    if (!aresetn || loss_of_frame) begin
      prev_err <= 1'b0;
    end else if (sef_pulse) begin
      prev_err <= 1'b0;
    end else if (fas_word_valid) begin
      prev_err <= fas_word_err;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= CNT8_RST;
    end else if (sef_pulse && base != 8'hFF) begin
      count <= base + 8'h01;
    end else begin
      count <= base;
    end
  end
endmodule

// *** hdl/e1pm_top.sv ***
// Contract
// - sixteen-bit count of framing alignment errors since last read
// - alignment error count upper byte at one register, lower byte next
// - every counter clears when read and powers up at zero
// - clear of sixteen-bit counter completes after upper then lower read
// - eight-bit count of severely errored frames since last read
// - severe frame is two consecutive bad alignment words while in frame
// - sixteen-bit count of CRC-4 sync bit errors, upper byte own register
// - CRC-4 sync error lower byte in companion register, same order rules
`timescale 1ns/1ps
module e1pm_top
  import e1pm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // framer strobes
  input wire logic fas_err,
  input wire logic fas_word_valid,
  input wire logic loss_of_frame,
  input wire logic crc4_sync_err,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq
);
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [11:0] wr_idx;
  logic [11:0] rd_idx;
  logic rd_fire;
  logic [31:0] next_rdata;
  logic next_rerr;
  logic rd_fas_hi;
  logic rd_fas_lo;
  logic rd_sef;
  logic rd_crc_hi;
  logic rd_crc_lo;
  logic [7:0] fas_hi;
  logic [7:0] fas_lo;
  logic [7:0] crc_hi;
  logic [7:0] crc_lo;
  logic [7:0] sef_count;
  logic fas_sat;
  logic crc_sat;
  logic sef_sat;
  logic sef_pulse;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_set;

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = aw_addr[13:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_idx == IRQ_STAT_IDX || wr_idx == IRQ_MASK_IDX) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one cycle to data
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[13:2];
  assign rd_fas_hi = rd_fire && rd_idx == FAS_HI_IDX;
  assign rd_fas_lo = rd_fire && rd_idx == FAS_LO_IDX;
  assign rd_sef = rd_fire && rd_idx == SEF_IDX;
  assign rd_crc_hi = rd_fire && rd_idx == CRC_HI_IDX;
  assign rd_crc_lo = rd_fire && rd_idx == CRC_LO_IDX;

  always_comb begin
    next_rdata = 32'h00000000;
    next_rerr = 1'b0;
    case (rd_idx)
      FAS_HI_IDX: next_rdata[7:0] = fas_hi;
      FAS_LO_IDX: next_rdata[7:0] = fas_lo;
      SEF_IDX: next_rdata[7:0] = sef_count;
      CRC_HI_IDX: next_rdata[7:0] = crc_hi;
      CRC_LO_IDX: next_rdata[7:0] = crc_lo;
      IRQ_STAT_IDX: next_rdata[IRQ_W-1:0] = irq_stat;
      IRQ_MASK_IDX: next_rdata[IRQ_W-1:0] = irq_mask;
      EVT_STAT_IDX: next_rdata[0] = loss_of_frame;
      default: next_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // counters
  e1pm_cnt16 u_fas (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_pulse(fas_err),
    .rd_hi(rd_fas_hi),
    .rd_lo(rd_fas_lo),
    .hi_byte(fas_hi),
    .lo_byte(fas_lo),
    .saturated(fas_sat)
  );

  e1pm_cnt16 u_crc (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_pulse(crc4_sync_err),
    .rd_hi(rd_crc_hi),
    .rd_lo(rd_crc_lo),
    .hi_byte(crc_hi),
    .lo_byte(crc_lo),
    .saturated(crc_sat)
  );

  e1pm_sef u_sef (
    .aclk(aclk),
    .aresetn(aresetn),
    .fas_word_valid(fas_word_valid),
    .fas_word_err(fas_err),
    .loss_of_frame(loss_of_frame),
    .rd_clear(rd_sef),
    .count(sef_count),
    .sef_pulse(sef_pulse),
    .saturated(sef_sat)
  );

  // interrupts: sticky status, write one to clear, set wins
  assign irq_set = {fas_sat || crc_sat || sef_sat, crc4_sync_err, sef_pulse, fas_err};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
    end else if (wr_fire && wr_idx == IRQ_STAT_IDX && w_strb[0]) begin
      irq_stat <= (irq_stat & ~w_data[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= IRQ_MASK_RST;
    end else if (wr_fire && wr_idx == IRQ_MASK_IDX && w_strb[0]) begin
      irq_mask <= w_data[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);
endmodule

// *** tb/e1pm_top_props.sv ***
`timescale 1ns/1ps
module e1pm_top_props
  import e1pm_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read unanswered");
  a_rd_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
    else $error("read answer without request");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  a_rd_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_byte_only: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper data bits set");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  a_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write unanswered");
  a_wr_single: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write taken");
endmodule
bind e1pm_top e1pm_top_props u_props(.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .s_axi_bvalid, .s_axi_bready);

// *** tb/e1pm_top_tb.sv ***
`timescale 1ns/1ps
module e1pm_top_tb;
  import e1pm_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic fas_err, fas_word_valid, loss_of_frame, crc4_sync_err, irq;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, wd;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] r = 32'hAE09D683;
  logic [11:0] wa;
  int n_mismatch, comparisons, gen, k;
  int fc, fs, fsv, sc, cc, cs, csv, prv, st, mk, hw, ed, er, eb;
  always #2.5 aclk = ~aclk;
  e1pm_top u_dut(.aclk, .aresetn, .fas_err, .fas_word_valid, .loss_of_frame, .crc4_sync_err,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick();
    @(posedge aclk);
    k++;
    if (k > 200) begin
      n_mismatch++;
      $display("[ERR] %0t no answer", $time);
      give_verdict();
    end
  endtask
  task automatic rd(input logic [11:0] ix);
    @(posedge aclk);
    s_axi_araddr <= {ix, 2'h0};
    s_axi_arvalid <= 1'h1;
    k = 0;
    do tick(); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    tick();
    s_axi_rready <= 1'h1;
    do tick(); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  task automatic wr(input logic [11:0] ix, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {ix, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    k = 0;
    do begin
      tick();
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, eb);
  endtask
  // reference counters, updated at the edge the design samples
  always @(posedge aclk) begin
    if (aresetn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        ed = 0;
        er = 0;
        case (s_axi_araddr[13:2])
          FAS_HI_IDX: begin ed = fc >> 8; fs = fc & 255; fsv = 1; fc = 0; end
          FAS_LO_IDX: begin ed = fsv ? fs : fc & 255; fsv = 0; end
          SEF_IDX: begin ed = sc; sc = 0; end
          CRC_HI_IDX: begin ed = cc >> 8; cs = cc & 255; csv = 1; cc = 0; end
          CRC_LO_IDX: begin ed = csv ? cs : cc & 255; csv = 0; end
          IRQ_STAT_IDX: ed = st;
          IRQ_MASK_IDX: ed = mk;
          EVT_STAT_IDX: ed = loss_of_frame;
          default: er = RESP_SLVERR;
        endcase
      end
      // write lands the edge after both halves are held
      if (hw == 3) begin
        hw = 0;
        eb = (wa == IRQ_STAT_IDX || wa == IRQ_MASK_IDX) ? 0 : RESP_SLVERR;
        if (wa == IRQ_STAT_IDX) st &= ~wd;
        if (wa == IRQ_MASK_IDX) mk = wd & 15;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        wa = s_axi_awaddr[13:2];
        hw |= 1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd = s_axi_wdata;
        hw |= 2;
      end
      // set wins over a clear in the same cycle; bit 3 flags an event at all ones
      if (fas_err) begin
        st |= fc == 65535 ? 9 : 1;
        fc += fc < 65535;
      end
      if (crc4_sync_err) begin
        st |= cc == 65535 ? 12 : 4;
        cc += cc < 65535;
      end
      if (loss_of_frame) prv = 0;
      else if (fas_word_valid) begin
        if (fas_err && prv) begin
          st |= sc == 255 ? 10 : 2;
          sc += sc < 255;
        end
        prv = fas_err && !prv;
      end
    end
    r = nx(r);
    fas_word_valid <= gen == 2 || gen == 1 && r[0];
    fas_err <= gen == 2 || gen == 1 && r[0] && r[1];
    crc4_sync_err <= gen == 2 || gen == 1 && r[2];
    loss_of_frame <= gen == 3 || gen == 1 && r[15:10] == 6'h0;
  end
  always @(negedge aclk) if (aresetn) chk(irq, |(st & mk & 7));
  initial begin
    {fas_err, fas_word_valid, loss_of_frame, crc4_sync_err, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 8; i++) rd(12'h900 + 12'(i));
    wr(SEF_IDX, 32'h1);
    wr(IRQ_MASK_IDX, 32'h7);
    // framer held in loss of frame for the live status read
    gen = 3;
    rd(EVT_STAT_IDX);
    rd(IRQ_MASK_IDX);
    gen = 1;
    for (int i = 0; i < 80; i++) begin
      repeat (r[5:0]) @(posedge aclk);
      if (r[9]) wr(IRQ_STAT_IDX, r);
      rd(r[12] ? IRQ_STAT_IDX : FAS_HI_IDX + 12'(r[11:10]) + 12'(r[13]));
    end
    // saturate every counter, then read with events still arriving
    gen = 2;
    repeat (70000) @(posedge aclk);
    for (int i = 2; i < 7; i++) rd(12'h900 + 12'(i));
    rd(IRQ_STAT_IDX);
    give_verdict();
  end
endmodule
